/* rtl/spi_cfg_map.vh */
// Register offsets, field positions and reset values of the pin-control and baud block.
// Assumes a 32-bit AHB-Lite slave with one aligned word per register.
`ifndef SPI_CFG_MAP_VH
`define SPI_CFG_MAP_VH
`define OFS_PIN_CTRL 8'h00
`define OFS_BIT_RATE 8'h04
`define OFS_MODE_CTRL 8'h08
`define OFS_PIN_STATE 8'h0C
`define PC_SINGLE_WIRE 0
`define PC_HALT_WAIT 1
`define PC_SW_OE 3
`define PC_FAULT_EN 4
`define PC_MASK 8'h1B
`define BR_MASK 8'h77
`define BR_PRE_LSB 4
`define MC_ENABLE 0
`define MC_MASTER 1
`define MC_SEL_OE 2
`define RST_PIN_CTRL 8'h00
`define RST_BIT_RATE 8'h00
`define RST_MODE_CTRL 3'h0
`endif

/* rtl/baud_divider.v */
// Two-stage bit-rate divider: prescaler then power-of-two divider.
// Assumes codes may change at any time; counters keep counting and wrap at the new limit.
`timescale 1ns/1ps
`default_nettype none
module baud_divider #(
    parameter CODE_W = 3
) (
    input wire core_clk,
    input wire rst,
    input wire run,
    input wire [CODE_W-1:0] prescale_code,
    input wire [CODE_W-1:0] rate_divisor_code,
    output reg bit_tick
);
    reg [2:0] pre_cnt;
    reg [7:0] rate_cnt;
    wire pre_tick;
    wire [7:0] rate_last;
    assign pre_tick = (pre_cnt >= prescale_code);
    assign rate_last = (8'h02 << rate_divisor_code) - 8'h01;
    always @(posedge core_clk)
    begin
        if (rst || !run)
        begin
            pre_cnt <= 3'h0;
            rate_cnt <= 8'h00;
            bit_tick <= 1'b0;
        end
        else
        begin
            pre_cnt <= pre_tick ? 3'h0 : pre_cnt + 3'h1;
            bit_tick <= 1'b0;
            if (pre_tick)
            begin
                // Compare with >= so a smaller code mid-count still wraps
                if (rate_cnt >= rate_last)
                begin
                    rate_cnt <= 8'h00;
                    bit_tick <= 1'b1;
                end
                else
                begin
                    rate_cnt <= rate_cnt + 8'h01;
                end
            end
        end
    end
endmodule // baud_divider
`default_nettype wire

/* rtl/pin_router.v */
// Combinational pin function decode for the four serial pins.
// Assumes enables are registered by the caller.
`timescale 1ns/1ps
`default_nettype none
module pin_router (
    input wire enable,
    input wire master_select,
    input wire select_output_enable,
    input wire fault_detect_enable,
    input wire single_wire_select,
    input wire single_wire_output_enable,
    input wire bit_clk,
    input wire shift_out,
    input wire select_level,
    output reg sck_oe,
    output reg sck_o,
    output reg mosi_oe,
    output reg miso_oe,
    output reg ss_oe,
    output reg ss_o,
    output reg ss_is_input,
    output reg fault_watch,
    output reg [3:0] port_owned
);
    always @*
    begin
        sck_oe = 1'b0;
        sck_o = 1'b0;
        mosi_oe = 1'b0;
        miso_oe = 1'b0;
        ss_oe = 1'b0;
        ss_o = 1'b1;
        ss_is_input = 1'b0;
        fault_watch = 1'b0;
        port_owned = 4'hF;
        if (enable)
        begin
            port_owned = 4'h0;
            sck_oe = master_select;
            sck_o = master_select & bit_clk;
            if (single_wire_select)
            begin
                // Output enable drives pin
                // Idle data pin goes back to the port
                if (master_select)
                begin
                    mosi_oe = single_wire_output_enable;
                    port_owned[2] = 1'b1;
                end
                else
                begin
                    miso_oe = single_wire_output_enable;
                    port_owned[1] = 1'b1;
                end
            end
            else
            begin
                mosi_oe = master_select;
                miso_oe = ~master_select;
            end
            if (!master_select)
            begin
                ss_is_input = 1'b1;
            end
            else if (!fault_detect_enable)
            begin
                port_owned[3] = 1'b1;
            end
            else if (select_output_enable)
            begin
                ss_oe = 1'b1;
                ss_o = select_level;
            end
            else
            begin
                fault_watch = 1'b1;
                ss_is_input = 1'b1;
            end
        end
    end
    // shift_out reaches pins via caller data path
    wire unused_shift;
    assign unused_shift = shift_out;
endmodule // pin_router
`default_nettype wire

/* rtl/spi_pin_control_and_baud.v */
// Pin-control and baud-rate configuration of a serial interface, AHB-Lite slave.
// Assumes single-word transfers; shifter and data path live elsewhere.
`timescale 1ns/1ps
`default_nettype none
`include "spi_cfg_map.vh"
module spi_pin_control_and_baud (
    input wire core_clk,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire cpu_wait,
    input wire shift_out,
    input wire select_level,
    output reg clocks_run,
    output reg bit_tick,
    output reg sck_oe,
    output reg sck_o,
    output reg mosi_oe,
    output reg miso_oe,
    output reg ss_oe,
    output reg ss_o,
    output reg ss_is_input,
    output reg fault_watch,
    output reg [3:0] port_owned
);
    ////////////////////////////////////////////////////////////////////////
    reg [7:0] pin_and_fault_control;
    reg [7:0] bit_rate_divisors;
    reg [2:0] mode_ctrl;
    reg wr_pend;
    reg [7:0] wr_addr;
    reg bit_clk;
    wire interface_enable;
    wire master_select;
    wire select_output_enable;
    wire fault_detect_enable;
    wire single_wire_select;
    wire single_wire_output_enable;
    wire halt_in_wait;
    wire next_clocks_run;
    wire div_tick;
    wire r_sck_oe;
    wire r_sck_o;
    wire r_mosi_oe;
    wire r_miso_oe;
    wire r_ss_oe;
    wire r_ss_o;
    wire r_ss_in;
    wire r_fault;
    wire [3:0] r_port;
    wire take;
    ////////////////////////////////////////////////////////////////////////
    function [31:0] read_mux;
        input [7:0] a;
        input [7:0] pc;
        input [7:0] br;
        input [2:0] mc;
        input [3:0] po;
        begin
            case (a)
                `OFS_PIN_CTRL: read_mux = {24'h00_0000, pc & `PC_MASK};
                `OFS_BIT_RATE: read_mux = {24'h00_0000, br & `BR_MASK};
                `OFS_MODE_CTRL: read_mux = {29'h0000_0000, mc};
                `OFS_PIN_STATE: read_mux = {28'h000_0000, po};
                default: read_mux = 32'h0000_0000;
            endcase
        end
    endfunction
    assign interface_enable = mode_ctrl[`MC_ENABLE];
    assign master_select = mode_ctrl[`MC_MASTER];
    assign select_output_enable = mode_ctrl[`MC_SEL_OE];
    assign fault_detect_enable = pin_and_fault_control[`PC_FAULT_EN];
    assign single_wire_select = pin_and_fault_control[`PC_SINGLE_WIRE];
    assign single_wire_output_enable = pin_and_fault_control[`PC_SW_OE];
    assign halt_in_wait = pin_and_fault_control[`PC_HALT_WAIT];
    assign take = hsel & hready & htrans[1];
    assign next_clocks_run = ~(halt_in_wait & cpu_wait);
    ////////////////////////////////////////////////////////////////////////
    // Bus slave: zero wait states, always OKAY
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            pin_and_fault_control <= `RST_PIN_CTRL;
            bit_rate_divisors <= `RST_BIT_RATE;
            mode_ctrl <= `RST_MODE_CTRL;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend <= take & hwrite;
            if (take)
            begin
                wr_addr <= haddr[7:0];
            end
            if (take & ~hwrite)
            begin
                // Read data registered in address phase, ready for data phase
                hrdata <= read_mux(haddr[7:0], pin_and_fault_control,
                                   bit_rate_divisors, mode_ctrl, port_owned);
            end
            if (wr_pend)
            begin
                case (wr_addr)
                    `OFS_PIN_CTRL: pin_and_fault_control <= hwdata[7:0] & `PC_MASK;
                    `OFS_BIT_RATE: bit_rate_divisors <= hwdata[7:0] & `BR_MASK;
                    `OFS_MODE_CTRL: mode_ctrl <= hwdata[2:0];
                    default: mode_ctrl <= mode_ctrl;
                endcase
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    baud_divider #(
        .CODE_W(3)
    ) u_div (
        .core_clk(core_clk),
        .rst(rst),
        .run(interface_enable & master_select & next_clocks_run),
        .prescale_code(bit_rate_divisors[`BR_PRE_LSB +: 3]),
        .rate_divisor_code(bit_rate_divisors[2:0]),
        .bit_tick(div_tick)
    );
    pin_router u_pins (
        .enable(interface_enable),
        .master_select(master_select),
        .select_output_enable(select_output_enable),
        .fault_detect_enable(fault_detect_enable),
        .single_wire_select(single_wire_select),
        .single_wire_output_enable(single_wire_output_enable),
        .bit_clk(bit_clk),
        .shift_out(shift_out),
        .select_level(select_level),
        .sck_oe(r_sck_oe),
        .sck_o(r_sck_o),
        .mosi_oe(r_mosi_oe),
        .miso_oe(r_miso_oe),
        .ss_oe(r_ss_oe),
        .ss_o(r_ss_o),
        .ss_is_input(r_ss_in),
        .fault_watch(r_fault),
        .port_owned(r_port)
    );
    ////////////////////////////////////////////////////////////////////////
    // Outputs registered; pins lag the registers by one cycle
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            bit_clk <= 1'b0;
            clocks_run <= 1'b1;
            bit_tick <= 1'b0;
            sck_oe <= 1'b0;
            sck_o <= 1'b0;
            mosi_oe <= 1'b0;
            miso_oe <= 1'b0;
            ss_oe <= 1'b0;
            ss_o <= 1'b1;
            ss_is_input <= 1'b0;
            fault_watch <= 1'b0;
            port_owned <= 4'hF;
        end
        else
        begin
            // Bit clock toggles per divider tick, master only
            if (!(interface_enable & master_select))
            begin
                bit_clk <= 1'b0;
            end
            else if (div_tick)
            begin
                bit_clk <= ~bit_clk;
            end
            clocks_run <= next_clocks_run;
            bit_tick <= div_tick;
            sck_oe <= r_sck_oe;
            sck_o <= r_sck_o;
            mosi_oe <= r_mosi_oe;
            miso_oe <= r_miso_oe;
            ss_oe <= r_ss_oe;
            ss_o <= r_ss_o;
            ss_is_input <= r_ss_in;
            fault_watch <= r_fault;
            port_owned <= r_port;
        end
    end
endmodule // spi_pin_control_and_baud
`default_nettype wire

/* testbench/spi_cfg_monitor.sv */
// Checker on the ports of the pin-control and baud block.
// Assumes binding to the block's top module.
`timescale 1ns/1ps
`default_nettype none
module spi_cfg_monitor (
    input wire core_clk,
    input wire rst,
    input wire hreadyout,
    input wire hresp,
    input wire clocks_run,
    input wire bit_tick,
    input wire sck_oe,
    input wire mosi_oe,
    input wire miso_oe,
    input wire ss_oe,
    input wire ss_is_input,
    input wire fault_watch,
    input wire [3:0] port_owned
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////
    sequence s_pulse;
        bit_tick ##1 !bit_tick;
    endsequence
    // Two cycles, so a tick already in flight is tolerated
    sequence s_halted;
        !clocks_run ##1 !clocks_run;
    endsequence
    a_zero_wait: assert property (hreadyout && !hresp)
        else $error("bus stall or error response");
    a_tick_pulse: assert property (bit_tick |-> s_pulse)
        else $error("bit tick longer than one cycle");
    a_halt_tick: assert property (s_halted |-> !bit_tick)
        else $error("bit tick while clocks halted");
    a_off_ports: assert property (port_owned == 4'hF |-> !(sck_oe | mosi_oe | miso_oe | ss_oe))
        else $error("pin driven while port owned");
    a_slave_sel: assert property (!port_owned[0] && !sck_oe |-> ss_is_input && !ss_oe)
        else $error("slave select not a plain input");
    a_slave_nofault: assert property (!port_owned[0] && !sck_oe |-> !fault_watch && !port_owned[3])
        else $error("slave select used for fault or port");
    a_fault_out: assert property (!(fault_watch && ss_oe))
        else $error("select both fault input and output");
    a_ss_port: assert property (port_owned[3] |-> !ss_oe && !fault_watch)
        else $error("released select still in use");
    a_one_data: assert property (!(mosi_oe && miso_oe))
        else $error("both data pins driven");
    a_sck_owner: assert property (sck_oe |-> !port_owned[0] && (fault_watch || !ss_is_input))
        else $error("serial clock driven outside master");
endmodule // spi_cfg_monitor
`default_nettype wire

/* testbench/spi_far_end.sv */
// Far serial device: counts serial clock edges it receives.
// Assumes the bench resolves the clock wire, idle low.
`timescale 1ns/1ps
`default_nettype none
module spi_far_end (
    input wire core_clk,
    input wire sck_wire,
    output logic [15:0] edges
);
    logic last = 1'b0;
    initial edges = 16'h0000;
    always @(posedge core_clk)
    begin
        last <= sck_wire;
        if (sck_wire !== last)
            edges <= edges + 16'h0001;
    end
endmodule // spi_far_end
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the pin-control and baud block.
// Assumes one AHB-Lite slave, zero wait states allowed but not assumed.
`timescale 1ns/1ps
`default_nettype none
`include "spi_cfg_map.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    logic core_clk = 0, rst = 1, hsel = 0, hwrite = 0, cpu_wait = 0;
    logic shift_out = 0, select_level = 1;
    logic [31:0] haddr = 0, hwdata = 0, rd;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    wire [31:0] hrdata;
    wire [3:0] port_owned;
    wire hreadyout, hresp, clocks_run, bit_tick, sck_oe, sck_o, mosi_oe, miso_oe;
    wire ss_oe, ss_o, ss_is_input, fault_watch;
    wire hready = hreadyout;
    wire [15:0] edges;
    int err_count = 0, checks_done = 0;
    always #4 core_clk = ~core_clk;
    spi_pin_control_and_baud DUT (
        .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cpu_wait(cpu_wait), .shift_out(shift_out),
        .select_level(select_level), .clocks_run(clocks_run), .bit_tick(bit_tick),
        .sck_oe(sck_oe), .sck_o(sck_o), .mosi_oe(mosi_oe), .miso_oe(miso_oe), .ss_oe(ss_oe),
        .ss_o(ss_o), .ss_is_input(ss_is_input), .fault_watch(fault_watch),
        .port_owned(port_owned)
    );
    spi_far_end far (.core_clk(core_clk), .sck_wire(sck_oe ? sck_o : 1'b0), .edges(edges));
    ////////////////////////////////
    task close_out;
        if (err_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Bounded: a hung bus ends the run
    task xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge core_clk); while (hready !== 1'b1 && ++n < 64);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge core_clk); while (hready !== 1'b1 && ++n < 64);
        rd = hrdata;
        if (n >= 64)
        begin
            err_count++;
            close_out;
        end
    endtask
    task rchk(input logic [31:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0000_0000);
        `CHK(rd, e)
    endtask
    task tick_wait(output int n);
        n = 0;
        do @(posedge core_clk); while (bit_tick !== 1'b1 && ++n < 3000);
        if (n >= 3000)
        begin
            err_count++;
            close_out;
        end
    endtask
    task count_ticks(output int n);
        n = 0;
        repeat (40)
        begin
            @(posedge core_clk);
            if (bit_tick === 1'b1)
                n++;
        end
    endtask
    ////////////////////////////////
    task s_regs;
        rchk(`OFS_PIN_CTRL, 32'h0000_0000);
        xfer(`OFS_PIN_CTRL, 1'b1, 32'hFFFF_FFFF);
        rchk(`OFS_PIN_CTRL, 32'h0000_001B);
        xfer(`OFS_BIT_RATE, 1'b1, 32'hFFFF_FFFF);
        rchk(`OFS_BIT_RATE, 32'h0000_0077);
        rchk(`OFS_PIN_STATE, 32'h0000_000F);
        xfer(32'h0000_0010, 1'b1, 32'h0000_00FF);
        rchk(32'h0000_0010, 32'h0000_0000);
    endtask
    // Bits: 0 enable, 1 master, 2 select out, 3 fault, 4 single wire, 5 wire oe
    task s_pins;
        logic [5:0] c;
        for (int i = 0; i < 64; i++)
        begin
            c = i[5:0];
            xfer(`OFS_MODE_CTRL, 1'b1, {29'h0, c[2:0]});
            xfer(`OFS_PIN_CTRL, 1'b1, {27'h0, c[3], c[5], 2'b00, c[4]});
            select_level <= c[4];
            repeat (2) @(posedge core_clk);
            `CHK(port_owned, {!c[0] | (c[1] & !c[3]), !c[0] | (c[4] & c[1]),
                !c[0] | (c[4] & !c[1]), !c[0]})
            `CHK(sck_oe, c[0] & c[1])
            `CHK(mosi_oe, c[0] & c[1] & (!c[4] | c[5]))
            `CHK({ss_oe, fault_watch},
                {c[0] & c[1] & c[3] & c[2], c[0] & c[1] & c[3] & !c[2]})
            `CHK(ss_is_input, c[0] & (!c[1] | (c[3] & !c[2])))
            `CHK(ss_o, !(c[0] & c[1] & c[3] & c[2]) | c[4])
            `CHK(miso_oe, c[0] & !c[1] & (!c[4] | c[5]))
        end
    endtask
    task s_baud;
        int p, r, n;
        logic [15:0] e0;
        xfer(`OFS_PIN_CTRL, 1'b1, 32'h0000_0000);
        xfer(`OFS_MODE_CTRL, 1'b1, 32'h0000_0003);
        e0 = edges;
        for (int k = 0; k < 17; k++)
        begin
            p = (k < 8) ? k : ((k == 16) ? 7 : 0);
            r = (k < 8) ? 0 : ((k == 16) ? 7 : k - 8);
            xfer(`OFS_BIT_RATE, 1'b1, (p << 4) | r);
            // First period after a code change may mix old and new counts
            tick_wait(n);
            tick_wait(n);
            tick_wait(n);
            `CHK(n + 1, (p + 1) << (r + 1))
        end
        `CHK(edges > e0, 1'b1)
        xfer(`OFS_MODE_CTRL, 1'b1, 32'h0000_0001);
        repeat (3) @(posedge core_clk);
        count_ticks(n);
        `CHK(n, 0)
    endtask
    task s_wait;
        int n;
        xfer(`OFS_MODE_CTRL, 1'b1, 32'h0000_0003);
        xfer(`OFS_BIT_RATE, 1'b1, 32'h0000_0000);
        xfer(`OFS_PIN_CTRL, 1'b1, 32'h0000_0002);
        cpu_wait <= 1'b1;
        repeat (3) @(posedge core_clk);
        `CHK(clocks_run, 1'b0)
        count_ticks(n);
        `CHK(n, 0)
        xfer(`OFS_PIN_CTRL, 1'b1, 32'h0000_0000);
        repeat (3) @(posedge core_clk);
        `CHK(clocks_run, 1'b1)
        count_ticks(n);
        `CHK(n, 20)
        cpu_wait <= 1'b0;
    endtask
    initial
    begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        s_regs;
        s_pins;
        s_baud;
        s_wait;
        close_out;
    end
endmodule // tb
bind spi_pin_control_and_baud spi_cfg_monitor mon (
    .core_clk(core_clk), .rst(rst), .hreadyout(hreadyout), .hresp(hresp),
    .clocks_run(clocks_run), .bit_tick(bit_tick), .sck_oe(sck_oe), .mosi_oe(mosi_oe),
    .miso_oe(miso_oe), .ss_oe(ss_oe), .ss_is_input(ss_is_input), .fault_watch(fault_watch),
    .port_owned(port_owned)
);
`default_nettype wire
